// *** src/fps_pkg.sv ***
/*
  Constants shared by the program sequencer and its write buffer:
  command codes, link widths, register offsets, status bits, timing.
  Assumes a 50 MHz system clock and 16-bit word addressing on the link.
*/
package fps_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BUF_AW = 8;
    localparam int BUF_WORDS = 256;
    localparam int SECT_LSB = 17;
    localparam int LINE_LSB = 8;
    localparam int HP_LSB = 3;
    localparam int CLK_MHZ = 50;

    localparam logic [ADDR_W-1:0] UNLK1_ADDR = 24'h000555;
    localparam logic [ADDR_W-1:0] UNLK2_ADDR = 24'h0002AA;
    localparam logic [DATA_W-1:0] UNLK1_DATA = 16'h00AA;
    localparam logic [DATA_W-1:0] UNLK2_DATA = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_PROG   = 16'h00A0;
    localparam logic [DATA_W-1:0] CMD_WBUF   = 16'h0025;
    localparam logic [DATA_W-1:0] CMD_CONF   = 16'h0029;
    localparam logic [DATA_W-1:0] CMD_SUSP   = 16'h00B0;
    localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_STAT   = 16'h0070;
    localparam logic [DATA_W-1:0] MAX_WC     = 16'h00FF;
    localparam logic [DATA_W-1:0] ERASED     = 16'hFFFF;

    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL   = 8'h04;
    localparam logic [7:0] REG_PROT   = 8'h08;
    localparam logic [7:0] REG_CMD    = 8'h0C;
    localparam logic [7:0] REG_VOL    = 8'h10;
    localparam logic [7:0] REG_LAST   = 8'h14;

    localparam int SR_READY = 7;
    localparam int SR_SUSP  = 6;
    localparam int SR_FAIL  = 4;
    localparam int SR_ABORT = 3;
    localparam int SR_ECCOFF = 2;
    localparam int SR_ORIGIN = 1;
    localparam int CTRL_ECC2 = 0;
    localparam int CTRL_OVL_LSB = 1;
    localparam int CTRL_ESUSP = 3;
    localparam int CMD_CLR_STAT = 0;
    localparam int CMD_CLR_HIST = 1;
    localparam logic [1:0] OVL_NONE = 2'h0;
    localparam logic [1:0] OVL_NVPROT = 2'h1;
    localparam logic [1:0] OVL_VOLPROT = 2'h2;

    localparam int T_PROG_US = 100;
    localparam int PROG_CYCLES_DEF = T_PROG_US * CLK_MHZ;
    localparam int T_RECOV_NS = 10000;
    localparam int RECOV_CYCLES = (T_RECOV_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [3:0] {
        ST_RECOV  = 4'h0,
        ST_IDLE   = 4'h1,
        ST_UNLK1  = 4'h2,
        ST_UNLK2  = 4'h3,
        ST_WSETUP = 4'h4,
        ST_WLOAD  = 4'h5,
        ST_BCOUNT = 4'h6,
        ST_BFIRST = 4'h7,
        ST_BLOAD  = 4'h8,
        ST_BCONF  = 4'h9,
        ST_DRAIN  = 4'hA,
        ST_WAIT   = 4'hB,
        ST_SUSP   = 4'hC
    } fps_state_t;
endpackage : fps_pkg

// *** src/fps_buf_if.sv ***
/*
  Write-buffer port bundle between the sequencer and its buffer memory.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
interface fps_buf_if;
    logic                         wr_en;
    logic [fps_pkg::BUF_AW-1:0]   wr_addr;
    logic [fps_pkg::DATA_W-1:0]   wr_data;
    logic [fps_pkg::BUF_AW-1:0]   rd_addr;
    logic [fps_pkg::DATA_W-1:0]   rd_data;
    modport seq (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
    modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : fps_buf_if

// *** src/fps_buf_mem.sv ***
/*
  One-line write buffer, 256 words of 16 bits, registered read.
  Assumes the user tracks which words are valid; contents are not reset.
*/
`timescale 1ns/100ps
module fps_buf_mem
(
    input  wire logic   clk_sys,
    fps_buf_if.mem      bus
);
    import fps_pkg::*;

    logic [DATA_W-1:0] mem_q [BUF_WORDS];

    always_ff @(posedge clk_sys)
    begin
        if (bus.wr_en)
        begin
            mem_q[bus.wr_addr] <= bus.wr_data;
        end
        bus.rd_data <= mem_q[bus.rd_addr];
    end
endmodule : fps_buf_mem

// *** src/fps_top.sv ***
/*
  Program command sequencer of a serial NOR flash controller: word and
  burst-word programming, write-buffer programming, aborts, status.
  Assumes link pins come from another clock domain, an APB master on
  clk_sys, and an array port that ANDs each written word into the cells.
*/
// What this block does
// - Reprogrammed half-page turns its ECC off
// - Two-bit ECC: reprogram within half-page fails
// - Two unlocks, set-up, address/data starts program
// - Program runs alone, then back to standby
// - Burst words go to consecutive addresses
// - While busy only suspend and status accepted
// - Reset stops program, recovery, then read mode
// - Overlay program needs no unlocks; volatile bits
// - Buffer preset to all ones each operation
// - Protected sector aborts buffer program
// - First pair in sector, then sequential in line
// - Count down loads; outside line aborts
// - Confirm at sector starts autonomous program
// - Wrong count or missing confirm aborts
// - Word count above 255 aborts
// - Abort sets fail and abort; clear rules
// - Suspendable; returns to starting standby
`timescale 1ns/100ps
module fps_top
#(
    parameter int PROG_CYCLES = fps_pkg::PROG_CYCLES_DEF
)
(
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic [7:0]                   paddr,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  pwdata,
    output      logic [31:0]                  prdata,
    output      logic                         pready,
    output      logic                         pslverr,
    input  wire logic                         lk_ck,
    input  wire logic                         lk_cs_n,
    input  wire logic [fps_pkg::ADDR_W-1:0]   lk_addr,
    input  wire logic [fps_pkg::DATA_W-1:0]   lk_dq,
    output      logic                         arr_we,
    output      logic [fps_pkg::ADDR_W-1:0]   arr_addr,
    output      logic [fps_pkg::DATA_W-1:0]   arr_wdata,
    output      logic                         busy
);
    import fps_pkg::*;

    fps_buf_if buf_bus ();
    fps_buf_mem u_buf (.clk_sys (clk_sys), .bus (buf_bus.mem));

    // Link synchroniser: stage 1 is read only by stage 2
    logic                 ck_s1_q, ck_s2_q, ck_s3_q;
    logic                 cs_s1_q, cs_s2_q, cs_s3_q;
    logic [ADDR_W-1:0]    ad_s1_q, ad_s2_q;
    logic [DATA_W-1:0]    dq_s1_q, dq_s2_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            {ck_s1_q, ck_s2_q, ck_s3_q} <= 3'h0;
            {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
            ad_s1_q <= 24'h000000;
            ad_s2_q <= 24'h000000;
            dq_s1_q <= 16'h0000;
            dq_s2_q <= 16'h0000;
        end
        else
        begin
            {ck_s1_q, ck_s2_q, ck_s3_q} <= {lk_ck, ck_s1_q, ck_s2_q};
            {cs_s1_q, cs_s2_q, cs_s3_q} <= {lk_cs_n, cs_s1_q, cs_s2_q};
            ad_s1_q <= lk_addr;
            ad_s2_q <= ad_s1_q;
            dq_s1_q <= lk_dq;
            dq_s2_q <= dq_s1_q;
        end
    end

    logic wr_ev;
    logic cs_end;
    assign wr_ev  = ck_s2_q & ~ck_s3_q & ~cs_s2_q;
    assign cs_end = cs_s2_q & ~cs_s3_q;

    // Burst address tracking within one chip-select assertion
    logic              first_q;
    logic [ADDR_W-1:0] baddr_q;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
    assign waddr = first_q ? ad_s2_q : baddr_q;
    assign wdata = dq_s2_q;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            first_q <= 1'b1;
            baddr_q <= 24'h000000;
        end
        else if (wr_ev)
        begin
            first_q <= 1'b0;
            baddr_q <= waddr + 24'h000001;
        end
        else if (cs_s2_q)
        begin
            first_q <= 1'b1;
        end
    end

    // Software-visible control
    logic [31:0]          prot_q;
    logic [3:0]           ctrl_q;
    logic [DATA_W-1:0]    vol_q;
    logic [ADDR_W-1:0]    last_q;
    logic                 clr_stat, clr_hist;
    logic                 apb_wr;
    logic [1:0]           ovl;
    assign apb_wr   = psel & penable & pwrite;
    assign clr_stat = apb_wr & (paddr == REG_CMD) & pwdata[CMD_CLR_STAT];
    assign clr_hist = apb_wr & (paddr == REG_CMD) & pwdata[CMD_CLR_HIST];
    assign ovl      = ctrl_q[CTRL_OVL_LSB +: 2];

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prot_q <= 32'h00000000;
            ctrl_q <= 4'h0;
        end
        else if (apb_wr && paddr == REG_CTRL)
        begin
            ctrl_q <= pwdata[3:0];
        end
        else if (apb_wr && paddr == REG_PROT)
        begin
            prot_q <= pwdata;
        end
    end

    // Sequencer state
    fps_state_t            st_q;
    logic [12:0]           rcnt_q;
    logic [31:0]           tmr_q;
    logic [ADDR_W-1:0]     sa_q;
    logic [ADDR_W-1:0]     nxt_q;
    logic [15:0]           line_q;
    logic [7:0]            cnt_q;
    logic [BUF_WORDS-1:0]  valid_q;
    logic [8:0]            idx_q;
    logic                  dv_q;
    logic [7:0]            doff_q;
    logic [255:0]          op_hp_q, done_hp_q, eccoff_q;
    logic                  susp_pend_q, origin_q;
    logic                  set_abort, set_fail, prog_ok;
    logic                  sect_ok, in_line;
    logic                  done;
    logic [255:0]          reprog;

    assign sect_ok = waddr[ADDR_W-1:SECT_LSB] == sa_q[ADDR_W-1:SECT_LSB];
    assign in_line = waddr[ADDR_W-1:LINE_LSB] == line_q;
    assign done    = st_q == ST_WAIT && tmr_q == 32'(PROG_CYCLES - 1);
    assign reprog  = op_hp_q & done_hp_q;

    // Abort causes, all in the buffer loading path
    always_comb
    begin
        set_abort = 1'b0;
        if (wr_ev)
        begin
            case (st_q)
                ST_BCOUNT:
                    set_abort = !sect_ok || wdata > MAX_WC
                        || prot_q[5'(sa_q[SECT_LSB +: 5])];
                ST_BFIRST:
                    set_abort = !sect_ok;
                ST_BLOAD:
                    set_abort = !in_line || waddr != nxt_q;
                ST_BCONF:
                    set_abort = wdata != CMD_CONF || !sect_ok;
                default:
                    set_abort = 1'b0;
            endcase
        end
    end

    assign set_fail = set_abort
        | (done & ctrl_q[CTRL_ECC2] & (|reprog));
    assign prog_ok = done & ~set_fail;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_q        <= ST_RECOV;
            rcnt_q      <= 13'h0000;
            sa_q        <= 24'h000000;
            nxt_q       <= 24'h000000;
            line_q      <= 16'h0000;
            cnt_q       <= 8'h00;
            valid_q     <= '0;
            tmr_q       <= 32'h00000000;
            susp_pend_q <= 1'b0;
            origin_q    <= 1'b0;
            vol_q       <= 16'h0000;
        end
        else
        begin
            case (st_q)
                ST_RECOV:
                begin
                    rcnt_q <= rcnt_q + 13'h0001;
                    if (rcnt_q == 13'(RECOV_CYCLES - 1))
                    begin
                        st_q <= ST_IDLE;
                    end
                end
                ST_IDLE:
                begin
                    if (wr_ev && ovl != OVL_NONE && wdata == CMD_PROG)
                    begin
                        st_q <= ST_WSETUP;
                    end
                    else if (wr_ev && waddr == UNLK1_ADDR
                             && wdata == UNLK1_DATA)
                    begin
                        st_q <= ST_UNLK1;
                    end
                end
                ST_UNLK1:
                begin
                    if (wr_ev)
                    begin
                        st_q <= (waddr == UNLK2_ADDR && wdata == UNLK2_DATA)
                            ? ST_UNLK2 : ST_IDLE;
                    end
                end
                ST_UNLK2:
                begin
                    if (wr_ev)
                    begin
                        sa_q <= waddr;
                        origin_q <= ctrl_q[CTRL_ESUSP];
                        if (wdata == CMD_PROG)
                        begin
                            st_q <= ST_WSETUP;
                        end
                        else if (wdata == CMD_WBUF && ovl == OVL_NONE)
                        begin
                            st_q <= ST_BCOUNT;
                        end
                        else
                        begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
                ST_WSETUP:
                begin
                    if (wr_ev && ovl == OVL_VOLPROT)
                    begin
                        vol_q <= wdata;
                        st_q  <= ST_IDLE;
                    end
                    else if (wr_ev)
                    begin
                        line_q  <= waddr[ADDR_W-1:LINE_LSB];
                        valid_q <= BUF_WORDS'(1) << waddr[7:0];
                        st_q    <= ST_WLOAD;
                    end
                end
                ST_WLOAD:
                begin
                    // Words past the line end are dropped, not wrapped
                    if (wr_ev && in_line)
                    begin
                        valid_q[waddr[7:0]] <= 1'b1;
                    end
                    if (cs_end)
                    begin
                        st_q <= ST_DRAIN;
                    end
                end
                ST_BCOUNT:
                begin
                    if (wr_ev)
                    begin
                        cnt_q <= wdata[7:0];
                        st_q  <= set_abort ? ST_IDLE : ST_BFIRST;
                    end
                end
                ST_BFIRST:
                begin
                    if (wr_ev)
                    begin
                        line_q  <= waddr[ADDR_W-1:LINE_LSB];
                        nxt_q   <= waddr + 24'h000001;
                        valid_q <= BUF_WORDS'(1) << waddr[7:0];
                        cnt_q   <= cnt_q - 8'h01;
                        st_q    <= set_abort ? ST_IDLE
                            : (cnt_q == 8'h00) ? ST_BCONF : ST_BLOAD;
                    end
                end
                ST_BLOAD:
                begin
                    if (wr_ev)
                    begin
                        valid_q[waddr[7:0]] <= 1'b1;
                        nxt_q <= waddr + 24'h000001;
                        cnt_q <= cnt_q - 8'h01;
                        st_q  <= set_abort ? ST_IDLE
                            : (cnt_q == 8'h00) ? ST_BCONF : ST_BLOAD;
                    end
                end
                ST_BCONF:
                begin
                    if (wr_ev)
                    begin
                        st_q <= set_abort ? ST_IDLE : ST_DRAIN;
                    end
                end
                ST_DRAIN:
                begin
                    // Suspend is held until the timed phase to keep drain whole
                    if (wr_ev && wdata == CMD_SUSP)
                    begin
                        susp_pend_q <= 1'b1;
                    end
                    if (idx_q[8] && !dv_q)
                    begin
                        tmr_q <= 32'h00000000;
                        st_q  <= (susp_pend_q
                            || (wr_ev && wdata == CMD_SUSP))
                            ? ST_SUSP : ST_WAIT;
                        susp_pend_q <= 1'b0;
                    end
                end
                ST_WAIT:
                begin
                    tmr_q <= tmr_q + 32'h00000001;
                    if (done)
                    begin
                        st_q <= ST_IDLE;
                    end
                    else if (wr_ev && wdata == CMD_SUSP)
                    begin
                        st_q <= ST_SUSP;
                    end
                end
                ST_SUSP:
                begin
                    if (wr_ev && wdata == CMD_RESUME)
                    begin
                        st_q <= ST_WAIT;
                    end
                end
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // Drain the whole line; unloaded words go out as all ones
    assign buf_bus.wr_en   = wr_ev & (((st_q == ST_WSETUP)
        & (ovl != OVL_VOLPROT)) | ((st_q == ST_WLOAD) & in_line)
        | (st_q == ST_BFIRST) | (st_q == ST_BLOAD));
    assign buf_bus.wr_addr = waddr[7:0];
    assign buf_bus.wr_data = wdata;
    assign buf_bus.rd_addr = idx_q[7:0];

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            idx_q     <= 9'h000;
            dv_q      <= 1'b0;
            doff_q    <= 8'h00;
            arr_we    <= 1'b0;
            arr_addr  <= 24'h000000;
            arr_wdata <= 16'h0000;
            op_hp_q   <= '0;
            last_q    <= 24'h000000;
        end
        else
        begin
            dv_q   <= st_q == ST_DRAIN && !idx_q[8];
            doff_q <= idx_q[7:0];
            arr_we <= dv_q;
            if (st_q == ST_DRAIN && !idx_q[8])
            begin
                idx_q <= idx_q + 9'h001;
            end
            else if (st_q != ST_DRAIN)
            begin
                idx_q <= 9'h000;
            end
            if (st_q == ST_IDLE)
            begin
                op_hp_q <= '0;
            end
            if (dv_q)
            begin
                arr_addr  <= {line_q, doff_q};
                arr_wdata <= valid_q[doff_q] ? buf_bus.rd_data
                    : ERASED;
                if (valid_q[doff_q])
                begin
                    op_hp_q[{line_q[2:0], doff_q[7:HP_LSB]}] <= 1'b1;
                    last_q <= {line_q, doff_q};
                end
            end
        end
    end

    // Half-page history; aliases beyond 4 KB of tracked space
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            done_hp_q <= '0;
            eccoff_q  <= '0;
        end
        else if (done)
        begin
            done_hp_q <= done_hp_q | op_hp_q;
            eccoff_q  <= (clr_hist ? '0 : eccoff_q) | reprog;
        end
        else if (clr_hist)
        begin
            done_hp_q <= '0;
            eccoff_q  <= '0;
        end
    end

    // Set beats clear; success or software clears
    logic fail_q, abort_q;
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            fail_q  <= 1'b0;
            abort_q <= 1'b0;
        end
        else
        begin
            fail_q  <= set_fail | (fail_q & ~clr_stat & ~prog_ok);
            abort_q <= set_abort | (abort_q & ~clr_stat & ~prog_ok);
        end
    end

    logic [7:0] status;
    always_comb
    begin
        status = 8'h00;
        status[SR_READY]  = ~busy;
        status[SR_SUSP]   = st_q == ST_SUSP;
        status[SR_FAIL]   = fail_q;
        status[SR_ABORT]  = abort_q;
        status[SR_ECCOFF] = |eccoff_q;
        status[SR_ORIGIN] = origin_q;
    end

    assign busy = st_q == ST_RECOV || st_q == ST_DRAIN || st_q == ST_WAIT;

    // APB slave, zero wait states
    logic mapped;
    assign mapped = paddr == REG_STATUS || paddr == REG_CTRL
        || paddr == REG_PROT || paddr == REG_CMD
        || paddr == REG_VOL || paddr == REG_LAST;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h00000000;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                REG_STATUS: prdata <= {24'h000000, status};
                REG_CTRL:   prdata <= {28'h0000000, ctrl_q};
                REG_PROT:   prdata <= prot_q;
                REG_VOL:    prdata <= {16'h0000, vol_q};
                REG_LAST:   prdata <= {8'h00, last_q};
                default:    prdata <= 32'h00000000;
            endcase
        end
    end
endmodule : fps_top

// *** dv/fps_top_props.sv ***
/* Port checker for fps_top.
   Assumes a bind onto fps_top and one clock domain. */
`timescale 1ns/100ps
module fps_top_props
import fps_pkg::*;
#(parameter int PROG_CYCLES = 20)
(
    input wire logic                       clk_sys,
    input wire logic                       rst,
    input wire logic [7:0]                 paddr,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       arr_we,
    input wire logic [fps_pkg::ADDR_W-1:0] arr_addr,
    input wire logic                       busy
);
default clocking @(posedge clk_sys); endclocking
default disable iff (rst);
sequence s_acc; psel && penable; endsequence
sequence s_rd; psel && !penable && !pwrite && paddr == REG_STATUS;
endsequence
property p_rec; $fell(rst) |-> (busy && !arr_we) [*8]; endproperty
a_rec: assert property (p_rec) else $error("early exit");
property p_seq;
    arr_we && $past(arr_we) |-> arr_addr == $past(arr_addr) + 24'h1;
endproperty
a_seq: assert property (p_seq) else $error("address gap");
property p_web; arr_we |-> busy; endproperty
a_web: assert property (p_web) else $error("write idle");
property p_end; $fell(busy) |-> !arr_we && !$past(arr_we); endproperty
a_end: assert property (p_end) else $error("write at end");
// Ready bit left out while suspended
property p_rdy;
    s_rd ##1 !prdata[SR_SUSP] |-> prdata[SR_READY] == !$past(busy);
endproperty
a_rdy: assert property (p_rdy) else $error("ready bit");
property p_err; s_acc ##0 paddr > REG_LAST |-> pslverr; endproperty
a_err: assert property (p_err) else $error("no slave error");
property p_ok;
    s_acc ##0 paddr <= REG_LAST && paddr[1:0] == 2'h0 |-> !pslverr;
endproperty
a_ok: assert property (p_ok) else $error("false slave error");
property p_prd; s_acc |-> pready; endproperty
a_prd: assert property (p_prd) else $error("wait state");
endmodule : fps_top_props
bind fps_top fps_top_props #(.PROG_CYCLES(PROG_CYCLES)) u_props (
    .clk_sys, .rst, .paddr, .psel, .penable, .pwrite, .prdata, .pready,
    .pslverr, .arr_we, .arr_addr, .busy);

// *** dv/fps_host_model.sv ***
/* Host side of the link: command frames for the sequencer.
   Assumes the caller waits out busy; clock idles between frames. */
`timescale 1ns/100ps
module fps_host_model
import fps_pkg::*;
(
    output logic                       lk_ck,
    output logic                       lk_cs_n,
    output logic [fps_pkg::ADDR_W-1:0] lk_addr,
    output logic [fps_pkg::DATA_W-1:0] lk_dq
);
initial {lk_ck, lk_cs_n, lk_addr, lk_dq} = {2'b01, 40'h0};
// Released lines flip so stale values never look valid
task automatic frame(input logic [23:0] a, input logic [15:0] d,
                     input int n);
    lk_cs_n = 0;
    for (int i = 0; i < n; i++)
    begin
        lk_addr = a + 24'(i);
        lk_dq = d + 16'(i);
        #80 lk_ck = 1;
        #80 lk_ck = 0;
    end
    #80 lk_cs_n = 1;
    lk_addr = ~lk_addr;
    lk_dq = ~lk_dq;
    #160;
endtask : frame
task automatic unlock();
    frame(UNLK1_ADDR, UNLK1_DATA, 1);
    frame(UNLK2_ADDR, UNLK2_DATA, 1);
endtask : unlock
task automatic prog(input logic [23:0] a, input logic [15:0] d,
                    input int n);
    unlock();
    frame(a, CMD_PROG, 1);
    frame(a, d, n);
endtask : prog
task automatic bufp(input logic [23:0] a, input logic [15:0] wc, d,
                    input int n, input logic [15:0] cf);
    unlock();
    frame(a, CMD_WBUF, 1);
    frame(a, wc, 1);
    for (int i = 0; i < n; i++)
        frame(a + 24'(i), d + 16'(i), 1);
    frame(a, cf, 1);
endtask : bufp
endmodule : fps_host_model

// *** dv/flash_program_sequencer_test.sv ***
/* Bench for fps_top: word, buffer, abort and ECC cases over the link.
   Assumes fps_host_model on the link and APB driven here. */
`timescale 1ns/100ps
module flash_program_sequencer_test;
import fps_pkg::*;
logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
logic [7:0] paddr = '0;
logic [31:0] pwdata = '0, prdata, rd_q;
logic pready, pslverr, err_q, lk_ck, lk_cs_n, arr_we, busy;
logic [ADDR_W-1:0] lk_addr, arr_addr;
logic [DATA_W-1:0] lk_dq, arr_wdata, img [256];
int failures = 0, checked = 0, nwe = 0, n0;
always #10 clk_sys = ~clk_sys;
fps_top #(.PROG_CYCLES(2000)) fps_top_i (.clk_sys, .rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .lk_ck,
    .lk_cs_n, .lk_addr, .lk_dq, .arr_we, .arr_addr, .arr_wdata, .busy);
fps_host_model fps_host_model_i (.lk_ck, .lk_cs_n, .lk_addr, .lk_dq);
always @(posedge clk_sys)
    if (arr_we === 1'b1)
    begin
        img[arr_addr[7:0]] <= arr_wdata;
        nwe <= nwe + 1;
    end
task automatic chk(input logic [32:0] s, e);
    checked++;
    if (s !== e)
    begin
        failures++;
        $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
endtask : chk
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    {rd_q, err_q} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
endtask : apb
task automatic sts(input logic [31:0] m, e);
    apb(0, REG_STATUS, 0);
    chk(rd_q & m, e);
endtask : sts
task automatic idle();
    repeat (8) @(posedge clk_sys);
    for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk_sys);
    chk(busy, 0);
endtask : idle
task automatic t_reset();
    int c = 0;
    while (busy === 1'b1 && c < 2000)
    begin
        @(posedge clk_sys);
        c++;
    end
    chk(c > RECOV_CYCLES - 3 && c < RECOV_CYCLES + 3, 1);
    sts(32'h80, 32'h80);
    $display("reset done");
endtask : t_reset
task automatic t_word();
    n0 = nwe;
    fps_host_model_i.prog(24'h000105, 16'h1234, 2);
    idle();
    chk(nwe - n0, 256);
    chk(img[5], 16'h1234);
    chk(img[6], 16'h1235);
    $display("word done");
endtask : t_word
task automatic t_abort();
    for (int k = 0; k < 4; k++)
    begin
        apb(1, REG_PROT, k == 0 ? 32'h4 : 32'h0);
        n0 = nwe;
        case (k)
            0: fps_host_model_i.bufp(24'h040000, 0, 0, 1, CMD_CONF);
            1: fps_host_model_i.bufp(24'h0200FE, 3, 0, 4, CMD_CONF);
            2: fps_host_model_i.bufp(24'h020000, 16'h100, 0, 1, CMD_CONF);
            default: fps_host_model_i.bufp(24'h020000, 0, 0, 1, CMD_RESUME);
        endcase
        repeat (8) @(posedge clk_sys);
        sts(32'h18, 32'h18);
        chk(nwe - n0, 0);
        if (k < 3) apb(1, REG_CMD, 1);
        if (k < 3) sts(32'h18, 0);
    end
    $display("abort done");
endtask : t_abort
task automatic t_buf();
    n0 = nwe;
    fps_host_model_i.bufp(24'h020110, 1, 16'hABCD, 2, CMD_CONF);
    idle();
    chk(nwe - n0, 256);
    chk(img[8'h11], 16'hABCE);
    chk(img[8'h12], 16'hFFFF);
    sts(32'h18, 0);
    fps_host_model_i.bufp(24'h020110, 0, 0, 1, CMD_CONF);
    for (int i = 0; i < 99 && arr_we !== 1'b1; i++) @(posedge clk_sys);
    rst <= 1;
    repeat (2) @(posedge clk_sys);
    rst <= 0;
    n0 = nwe;
    t_reset();
    chk(nwe, n0);
    $display("buffer done");
endtask : t_buf
task automatic t_ecc();
    apb(1, REG_CMD, 3);
    apb(1, REG_CTRL, 1);
    fps_host_model_i.prog(24'h000300, 16'hFF0F, 1);
    idle();
    sts(32'h1C, 0);
    n0 = nwe;
    fps_host_model_i.prog(24'h000300, 16'hF00F, 1);
    fps_host_model_i.prog(24'h000310, 16'h0000, 1);
    idle();
    chk(nwe - n0, 256);
    sts(32'h1C, 32'h14);
    apb(0, 8'h40, 0);
    chk({err_q, rd_q}, {1'b1, 32'h0});
    $display("ecc done");
endtask : t_ecc
task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask : results
initial
begin
    repeat (16) @(posedge clk_sys);
    rst <= 0;
    t_reset();
    t_word();
    t_abort();
    t_buf();
    t_ecc();
    results();
end
// About four times the expected run
initial
begin
    #1000000;
    failures++;
    results();
end
endmodule : flash_program_sequencer_test
